// ---- sct_defines.svh ----
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH
// ==========================================
// Key sector codes
`define SCT_ACT_ERC 16'h0003
`define SCT_ACT_WSAME 16'h0002
`define SCT_FN_SET 16'h0001
`define SCT_FN_GET 16'h0002
`define SCT_FN_WS_BLK_PAT 16'h0101
`define SCT_FN_WS_BLK_SEC 16'h0102
`define SCT_SEL_READ 16'h0001
`define SCT_SEL_WRITE 16'h0002
`define SCT_MIN_LIMIT 16'h0041
`define SCT_LIMIT_RST 16'h0000
// ==========================================
// Taskfile result values
`define SCT_ERR_OK 8'h00
`define SCT_ERR_ABORT 8'h04
`define SCT_STAT_OK 8'h50
`define SCT_STAT_ERR 8'h51
`define SCT_XSTAT_WS_UNREC 16'h0017
// ==========================================
// Timing
`define SCT_UNIT_MS 100
`define SCT_CLK_MHZ 250
`define SCT_UNIT_CYCLES (`SCT_UNIT_MS * 1000 * `SCT_CLK_MHZ)
// ==========================================
// Interrupt status bits
`define SCT_IRQ_DONE 0
`define SCT_IRQ_ERR 1
`define SCT_IRQ_TIMEOUT 2
`define SCT_IRQ_W 3
`endif

// ---- sct_pkg.sv ----
package sct_pkg;
   typedef struct packed {
      logic [15:0] action;
      logic [15:0] func;
      logic [15:0] sel;
      logic [15:0] value;
   } sct_key_s;
   typedef struct packed {
      logic [7:0] error;
      logic [7:0] sect_cnt;
      logic [7:0] sect_num;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] dev_head;
      logic [7:0] status;
   } sct_tf_s;
   typedef struct packed {
      logic start;
      logic done;
      logic is_write;
      logic queued;
      logic in_order;
      logic streaming;
   } sct_cmd_s;
endpackage

// ---- sct_recovery_tmr.sv ----
`include "sct_defines.svh"
module sct_recovery_tmr #(
   parameter int unsigned UNIT_CYCLES = `SCT_UNIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic [15:0] i_limit,
   output logic o_expired
);
   logic [31:0] unit_cnt;
   logic [15:0] tick_cnt;
   logic [15:0] limit;
   logic running;
   logic unit_tick;

   assign unit_tick = running && (unit_cnt == UNIT_CYCLES - 1);

   // ==========================================
   // Run control
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         running <= 1'b0;
         limit <= 16'h0000;
      end else if (i_stop || o_expired) begin
         running <= 1'b0;
      end else if (i_start && !running && i_limit != 16'h0000) begin
         running <= 1'b1;
         limit <= i_limit;
      end
   end

   // ==========================================
   // Base 100 ms divider
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         unit_cnt <= 32'h0;
      end else if (!running || unit_tick) begin
         unit_cnt <= 32'h0;
      end else begin
         unit_cnt <= unit_cnt + 32'h1;
      end
   end

   // ==========================================
   // Unit counter and expiry pulse
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tick_cnt <= 16'h0000;
         o_expired <= 1'b0;
      end else begin
         o_expired <= 1'b0;
         if (!running) begin
            tick_cnt <= 16'h0000;
         end else if (unit_tick) begin
            tick_cnt <= tick_cnt + 16'h1;
            if (tick_cnt + 16'h1 == limit) begin
               o_expired <= 1'b1;
            end
         end
      end
   end
endmodule

// ---- sct_recovery_timer_cmd.sv ----
`include "sct_defines.svh"
module sct_recovery_timer_cmd #(
   parameter int unsigned UNIT_CYCLES = `SCT_UNIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_key_valid,
   input wire sct_pkg::sct_key_s i_key,
   input wire logic i_ws_done,
   input wire logic i_ws_unrec_err,
   input wire sct_pkg::sct_cmd_s i_cmd,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic o_tf_valid,
   output sct_pkg::sct_tf_s o_taskfile_result,
   output logic o_ws_start,
   output logic o_recovery_abort,
   output logic o_irq
);
   import sct_pkg::*;

   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_LIMITS = 4'h8;
   localparam logic [15:0] XSTAT_WS_UNREC = `SCT_XSTAT_WS_UNREC;

   typedef enum logic [1:0] {SCT_IDLE, SCT_WS_BUSY} sct_state_e;

   sct_state_e state;
   logic [15:0] read_limit;
   logic [15:0] write_limit;
   logic [`SCT_IRQ_W-1:0] irq_status;
   logic [`SCT_IRQ_W-1:0] irq_mask;
   logic is_erc;
   logic is_ws_blk;
   logic sel_ok;
   logic too_short;
   logic timed;
   logic tmr_start;
   logic tmr_stop;
   logic [15:0] tmr_limit;
   logic tmr_expired;
   logic ev_done;
   logic ev_err;
   sct_tf_s next_tf;
   logic next_tf_valid;
   logic [15:0] cur_limit;

   assign is_erc = i_key.action == `SCT_ACT_ERC;
   assign is_ws_blk = i_key.action == `SCT_ACT_WSAME &&
                      (i_key.func == `SCT_FN_WS_BLK_PAT || i_key.func == `SCT_FN_WS_BLK_SEC);
   assign sel_ok = i_key.sel == `SCT_SEL_READ || i_key.sel == `SCT_SEL_WRITE;
   assign too_short = i_key.value < `SCT_MIN_LIMIT;
   assign cur_limit = (i_key.sel == `SCT_SEL_WRITE) ? write_limit : read_limit;

   // ==========================================
   // Command timing eligibility
   // Streaming or out-of-order queued commands never time out
   assign timed = !i_cmd.streaming && !(i_cmd.queued && !i_cmd.in_order);
   // Start on issue (non-queued) or on execution start (queued in-order)
   assign tmr_start = i_cmd.start && timed;
   assign tmr_stop = i_cmd.done;
   assign tmr_limit = i_cmd.is_write ? write_limit : read_limit;

   sct_recovery_tmr #(
      .UNIT_CYCLES(UNIT_CYCLES)
   ) u_tmr (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_start(tmr_start),
      .i_stop(tmr_stop),
      .i_limit(tmr_limit),
      .o_expired(tmr_expired)
   );

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_recovery_abort <= 1'b0;
      end else begin
         o_recovery_abort <= tmr_expired;
      end
   end

   // ==========================================
   // Volatile limits
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         read_limit <= `SCT_LIMIT_RST;
         write_limit <= `SCT_LIMIT_RST;
      end else if (i_key_valid && state == SCT_IDLE && is_erc &&
                   i_key.func == `SCT_FN_SET && sel_ok && !too_short) begin
         if (i_key.sel == `SCT_SEL_READ) begin
            read_limit <= i_key.value;
         end else begin
            write_limit <= i_key.value;
         end
      end
   end

   // ==========================================
   // Blocking repeat-write sequencing
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= SCT_IDLE;
         o_ws_start <= 1'b0;
      end else begin
         o_ws_start <= 1'b0;
         unique case (state)
            SCT_IDLE: begin
               if (i_key_valid && is_ws_blk) begin
                  state <= SCT_WS_BUSY;
                  o_ws_start <= 1'b1;
               end
            end
            SCT_WS_BUSY: begin
               if (i_ws_done || i_ws_unrec_err) begin
                  state <= SCT_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Taskfile result
   always_comb begin
      next_tf = '0;
      next_tf.error = `SCT_ERR_OK;
      next_tf.status = `SCT_STAT_OK;
      next_tf_valid = 1'b0;
      ev_done = 1'b0;
      ev_err = 1'b0;
      if (state == SCT_WS_BUSY) begin
         if (i_ws_unrec_err) begin
            next_tf_valid = 1'b1;
            ev_err = 1'b1;
            next_tf.error = `SCT_ERR_ABORT;
            next_tf.status = `SCT_STAT_ERR;
            next_tf.sect_cnt = XSTAT_WS_UNREC[7:0];
            next_tf.sect_num = XSTAT_WS_UNREC[15:8];
         end else if (i_ws_done) begin
            next_tf_valid = 1'b1;
            ev_done = 1'b1;
         end
      end else if (i_key_valid && is_erc) begin
         next_tf_valid = 1'b1;
         if (!sel_ok || (i_key.func != `SCT_FN_SET && i_key.func != `SCT_FN_GET) ||
             (i_key.func == `SCT_FN_SET && too_short)) begin
            ev_err = 1'b1;
            next_tf.error = `SCT_ERR_ABORT;
            next_tf.status = `SCT_STAT_ERR;
         end else begin
            ev_done = 1'b1;
            if (i_key.func == `SCT_FN_GET) begin
               next_tf.sect_cnt = cur_limit[7:0];
               next_tf.sect_num = cur_limit[15:8];
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tf_valid <= 1'b0;
         o_taskfile_result <= '0;
      end else begin
         o_tf_valid <= next_tf_valid;
         if (next_tf_valid) begin
            o_taskfile_result <= next_tf;
         end
      end
   end

   // ==========================================
   // Interrupt status, cleared by read, set wins
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_status <= '0;
      end else begin
         irq_status <= ((i_reg_rd && i_reg_addr == REG_STATUS) ? '0 : irq_status) |
                       {tmr_expired, ev_err, ev_done};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_mask <= '0;
      end else if (i_reg_wr && i_reg_addr == REG_MASK) begin
         irq_mask <= i_reg_wdata[`SCT_IRQ_W-1:0];
      end
   end

   assign o_irq = |(irq_status & irq_mask);

   // ==========================================
   // Register read port
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata <= 32'h0;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            REG_STATUS: o_reg_rdata <= {29'h0, irq_status};
            REG_MASK: o_reg_rdata <= {29'h0, irq_mask};
            REG_LIMITS: o_reg_rdata <= {write_limit, read_limit};
            default: o_reg_rdata <= 32'h0;
         endcase
      end else begin
         o_reg_rdata <= 32'h0;
      end
   end
endmodule

// ---- sct_host_model.sv ----
module sct_host_model (
   input wire logic i_clk,
   output logic o_key_valid,
   output sct_pkg::sct_key_s o_key
);
   timeunit 1ns;
   timeprecision 1ps;
   import sct_pkg::*;
   initial begin
      o_key_valid = 1'b0;
      o_key = '0;
   end
   // ==========================================
   // One key sector, released to inverted data
   task automatic send(input logic [15:0] a, f, s, v);
      @(posedge i_clk);
      o_key_valid <= 1'b1;
      o_key <= {a, f, s, v};
      @(posedge i_clk);
      o_key_valid <= 1'b0;
      o_key <= ~{a, f, s, v};
   endtask
endmodule

// ---- sct_recovery_timer_cmd_checker.sv ----
`include "sct_defines.svh"
module sct_recovery_timer_cmd_checker #(
   parameter int unsigned UNIT_CYCLES = `SCT_UNIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_key_valid,
   input wire sct_pkg::sct_key_s i_key,
   input wire logic i_ws_done,
   input wire logic i_ws_unrec_err,
   input wire sct_pkg::sct_cmd_s i_cmd,
   input wire logic o_tf_valid,
   input wire sct_pkg::sct_tf_s o_taskfile_result,
   input wire logic o_ws_start,
   input wire logic o_recovery_abort
);
   timeunit 1ns;
   timeprecision 1ps;
   import sct_pkg::*;
   logic busy;
   logic ws;
   logic run;
   logic erc;
   logic q;
   logic [15:0] rl;
   logic [15:0] wl;
   logic [31:0] cnt;
   logic [31:0] lim;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // Write-same busy from the cycle its start pulse shows
   assign ws = busy || o_ws_start;
   assign erc = i_key_valid && i_key.action == `SCT_ACT_ERC && !ws;
   assign q = i_cmd.start && !i_cmd.streaming && !(i_cmd.queued && !i_cmd.in_order)
      && (i_cmd.is_write ? wl : rl) != 16'h0000;
   // ==========================================
   // Shadow limits, write-same and timer state
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rl <= '0;
         wl <= '0;
      end else if (erc && i_key.func == `SCT_FN_SET && i_key.value >= `SCT_MIN_LIMIT) begin
         rl <= i_key.sel == `SCT_SEL_READ ? i_key.value : rl;
         wl <= i_key.sel == `SCT_SEL_WRITE ? i_key.value : wl;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy <= 1'b0;
      end else begin
         busy <= ws && !i_ws_done && !i_ws_unrec_err;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run <= 1'b0;
         cnt <= '0;
         lim <= '0;
      end else if (q && !run) begin
         run <= 1'b1;
         cnt <= '0;
         lim <= (i_cmd.is_write ? wl : rl) * UNIT_CYCLES;
      end else begin
         run <= run && !i_cmd.done && !o_recovery_abort;
         cnt <= cnt + 1;
      end
   end
   // ==========================================
   // Assertions
   a_erc_answers: assert property (erc |=> o_tf_valid)
      else $error("recovery key got no answer");
   a_short_limit: assert property (erc && i_key.func == `SCT_FN_SET &&
      i_key.value < `SCT_MIN_LIMIT |=> o_taskfile_result.error == 8'h04
      && o_taskfile_result.status == 8'h51) else $error("short limit not aborted");
   a_get_ok: assert property (erc && i_key.func == `SCT_FN_GET && i_key.sel != 0
      && i_key.sel < 3 |=> o_taskfile_result.error == 8'h00
      && o_taskfile_result.status == 8'h50) else $error("bad success code");
   a_get_value: assert property (erc && i_key.func == `SCT_FN_GET && i_key.sel != 0
      && i_key.sel < 3 |=> {o_taskfile_result.sect_num, o_taskfile_result.sect_cnt}
      == ($past(i_key.sel) == 1 ? rl : wl)) else $error("wrong limit returned");
   a_ws_error: assert property (ws && i_ws_unrec_err |=> o_tf_valid
      && o_taskfile_result.sect_cnt == 8'h17 && o_taskfile_result.sect_num == 8'h00)
      else $error("bad write-same error result");
   a_ws_blocks: assert property (ws && !i_ws_done && !i_ws_unrec_err |=> !o_tf_valid)
      else $error("early write-same completion");
   a_untimed_quiet: assert property (!run |-> !o_recovery_abort)
      else $error("abort without running timer");
   a_abort_window: assert property (run |-> cnt <= lim + 2 &&
      (!o_recovery_abort || cnt + 1 >= lim)) else $error("abort off time");
endmodule
bind sct_recovery_timer_cmd sct_recovery_timer_cmd_checker #(.UNIT_CYCLES(UNIT_CYCLES)) i_chk (
   .i_clk, .i_rst_b, .i_key_valid, .i_key, .i_ws_done, .i_ws_unrec_err, .i_cmd,
   .o_tf_valid, .o_taskfile_result, .o_ws_start, .o_recovery_abort);

// ---- sct_recovery_timer_cmd_test.sv ----
module sct_recovery_timer_cmd_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sct_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_key_valid;
   sct_key_s i_key;
   logic i_ws_done = 1'b0;
   logic i_ws_unrec_err = 1'b0;
   sct_cmd_s i_cmd = '0;
   logic [3:0] i_reg_addr = '0;
   logic [31:0] i_reg_wdata = '0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [31:0] o_reg_rdata;
   logic o_tf_valid;
   sct_tf_s o_taskfile_result;
   logic o_ws_start;
   logic o_recovery_abort;
   logic o_irq;
   int bad_count = 0;
   int checks = 0;
   int aborts = 0;
   logic [15:0] lim [1:2] = '{16'h0, 16'h0};
   logic [15:0] v;
   always #2 i_clk = ~i_clk;
   always @(posedge i_clk) aborts += int'(o_recovery_abort === 1'b1);
   sct_host_model i_sct_host_model (.i_clk, .o_key_valid(i_key_valid), .o_key(i_key));
   sct_recovery_timer_cmd #(.UNIT_CYCLES(4)) i_sct_recovery_timer_cmd (.i_clk, .i_rst_b,
      .i_key_valid, .i_key, .i_ws_done, .i_ws_unrec_err, .i_cmd, .i_reg_addr, .i_reg_wdata,
      .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_tf_valid, .o_taskfile_result, .o_ws_start,
      .o_recovery_abort, .o_irq);
   // ==========================================
   // Expectations and compares
   function automatic logic [31:0] tf_exp(input logic [7:0] e, input logic [15:0] d);
      return {e, d[7:0], d[15:8], e == 8'h00 ? 8'h50 : 8'h51};
   endfunction
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk_tf(input logic t, input logic [31:0] e, input logic [31:0] m);
      @(negedge i_clk);
      cmp("tf_valid", {31'h0, t}, {31'h0, o_tf_valid});
      if (t) begin
         cmp("taskfile", e & m, {o_taskfile_result.error, o_taskfile_result.sect_cnt,
            o_taskfile_result.sect_num, o_taskfile_result.status} & m);
      end
   endtask
   task automatic reg_io(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_reg_wr <= w;
      i_reg_rd <= !w;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      @(negedge i_clk);
      if (!w) cmp("reg", d, o_reg_rdata);
   endtask
   task automatic erc(input logic [15:0] f, s, x, input logic [31:0] e, m);
      i_sct_host_model.send(16'h0003, f, s, x);
      chk_tf(1'b1, e, m);
   endtask
   task automatic set_lim(input logic [15:0] s, input logic [15:0] x);
      erc(16'h0001, s, x, tf_exp(x < 16'd65 ? 8'h04 : 8'h00, 0), 32'hff0000ff);
      if (x >= 16'd65) lim[s[1:0]] = x;
   endtask
   task automatic timed(input logic [5:0] c, input int stop, input int e);
      int n0;
      n0 = aborts;
      @(posedge i_clk);
      i_cmd <= c;
      @(posedge i_clk);
      i_cmd <= '0;
      repeat (stop) @(posedge i_clk);
      i_cmd.done <= 1'b1;
      @(posedge i_clk);
      i_cmd.done <= 1'b0;
      repeat (280 - stop) @(posedge i_clk);
      cmp("aborts", e, 32'(aborts - n0));
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================
   // Test sequence
   initial begin
      v = 16'($urandom(2));
      repeat (10) @(posedge i_clk);
      i_rst_b <= 1'b1;
      reg_io(0, 4'h8, 0);
      reg_io(0, 4'hc, 0);
      reg_io(1, 4'h4, 7);
      timed(6'b100000, 270, 0);
      erc(16'h0002, 1, 0, tf_exp(0, 0), '1);
      cmp("irq", 1, o_irq);
      reg_io(0, 4'h0, 1);
      cmp("irq", 0, o_irq);
      $display("test reset finished");
      for (int i = 0; i < 9; i++) begin
         v = i < 2 ? 16'(64 + i) : i == 8 ? 16'hffff : 16'(65 + $urandom % 65470);
         set_lim(16'(1 + i % 2), v);
         erc(16'h0002, 1, 0, tf_exp(0, lim[1]), '1);
         erc(16'h0002, 2, 0, tf_exp(0, lim[2]), '1);
      end
      erc(16'h0001, 3, 100, tf_exp(4, 0), 32'hff0000ff);
      erc(16'h0003, 1, 100, tf_exp(4, 0), 32'hff0000ff);
      reg_io(0, 4'h8, {lim[2], lim[1]});
      set_lim(1, 65);
      set_lim(2, 65);
      reg_io(1, 4'h4, 0);
      cmp("irq", 0, o_irq);
      reg_io(0, 4'h0, 3);
      reg_io(1, 4'h4, 7);
      $display("test limits finished");
      timed(6'b100000, 270, 1);
      timed(6'b101000, 100, 0);
      timed(6'b101110, 270, 1);
      timed(6'b100100, 270, 0);
      timed(6'b101001, 270, 0);
      cmp("irq", 1, o_irq);
      reg_io(0, 4'h0, 4);
      $display("test timers finished");
      i_sct_host_model.send(16'h0002, 16'h0101, 0, 0);
      @(negedge i_clk);
      cmp("ws_start", 1, o_ws_start);
      i_sct_host_model.send(16'h0003, 16'h0002, 1, 0);
      chk_tf(1'b0, 0, 0);
      @(posedge i_clk);
      i_ws_unrec_err <= 1'b1;
      @(posedge i_clk);
      i_ws_unrec_err <= 1'b0;
      chk_tf(1'b1, tf_exp(4, 16'h0017), '1);
      i_sct_host_model.send(16'h0002, 16'h0102, 0, 0);
      repeat (3) @(posedge i_clk);
      i_ws_done <= 1'b1;
      @(posedge i_clk);
      i_ws_done <= 1'b0;
      chk_tf(1'b1, tf_exp(0, 0), 32'hff0000ff);
      $display("test write same finished");
      end_of_test();
   end
   initial begin
      repeat (6000) @(posedge i_clk);
      bad_count++;
      end_of_test();
   end
endmodule
